// ==== logic/arb_if.sv ====
// Carrier between the controller and its priority arbiter
`timescale 1ns/1ns
interface arb_if;
  logic [vic_pkg::NUM_SRC-1:0]                     pending;
  logic [vic_pkg::NUM_SRC-1:0][vic_pkg::PRIO_W-1:0] priority_lvl;
  logic                                            valid;
  logic [vic_pkg::IDX_W-1:0]                       winner;

  modport controller (output pending, output priority_lvl, input valid, input winner);
  modport arbiter    (input pending, input priority_lvl, output valid, output winner);
endinterface

// ==== logic/priority_arbiter.sv ====
// Picks the highest priority pending normal source
`timescale 1ns/1ns
module priority_arbiter (
  arb_if.arbiter port
);
  logic [vic_pkg::PRIO_W-1:0] best;
  logic                       found;
  logic [vic_pkg::IDX_W-1:0]  idx;

  // Smaller level wins; scanning upward with a strict compare keeps the lower vector on a tie
  always_comb
  begin
    best  = '1;
    found = 1'b0;
    idx   = '0;
    for (int i = 0; i < vic_pkg::NUM_SRC; i++)
    begin
      if (port.pending[i] && (!found || port.priority_lvl[i] < best))
      begin
        found = 1'b1;
        best  = port.priority_lvl[i];
        idx   = vic_pkg::IDX_W'(i);
      end
    end
  end

  assign port.valid  = found;
  assign port.winner = idx;
endmodule

// ==== logic/vectored_irq_source_map.sv ====
// Vectored interrupt controller with a fixed source to vector map
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Up to thirty-two request inputs, each tied to its own vector number.
// - Two active-low requests to the core: normal and fast.
// - Handler addresses are held in storage the processor writes but cannot read back.
// - Vectored dispatch, each source with its own priority level.
// - Vector 0 is the wake event, vector 1 the software request.
// - Vector 4 is the general-purpose timer on a 32 kHz count.
// - Vector 6 parallel port DMA, vector 7 parallel port events.
// - Vector 8 USB DMA in both roles, vector 9 USB events.
// - Vectors 11 to 13 are card sources, storage variant only.
// - Vectors 15 to 18 are I2C, I2S, SPI and UART events.
// - Vector 19 pin port, 20 serial DMA, 21 supply detect, rest unused.
// - Any source may be fast, outranking all; ties go to lower vector.
// - Winner's handler address is loaded on the same edge that the normal request drops.
// - No nesting: a write to the active vector acknowledges before another.
module vectored_irq_source_map #(
  parameter bit STORAGE_VARIANT = 1'b1
) (
  input  wire logic                                      clock_in,
  input  wire logic                                      rst_in,
  input  wire logic                                      ce_in,
  input  wire logic                                      wake_event_source_in,
  input  wire logic                                      soft_request_source_in,
  input  wire logic                                      timer_source_in,
  input  wire logic                                      parallel_port_dma_source_in,
  input  wire logic                                      parallel_port_event_source_in,
  input  wire logic                                      usb_dma_source_in,
  input  wire logic                                      usb_event_source_in,
  input  wire logic                                      card_dma_source_in,
  input  wire logic                                      card_port_a_source_in,
  input  wire logic                                      card_port_b_source_in,
  input  wire logic                                      i2c_source_in,
  input  wire logic                                      i2s_source_in,
  input  wire logic                                      spi_source_in,
  input  wire logic                                      uart_source_in,
  input  wire logic                                      pin_port_source_in,
  input  wire logic                                      serial_source_a_in,
  input  wire logic                                      supply_detect_source_in,
  input  wire logic [vic_pkg::NUM_SRC-1:0]               enable_in,
  input  wire logic [vic_pkg::NUM_SRC-1:0]               fast_select_in,
  input  wire logic [vic_pkg::NUM_SRC*vic_pkg::PRIO_W-1:0] source_priority_in,
  input  wire logic                                      handler_wr_in,
  input  wire logic [vic_pkg::IDX_W-1:0]                 handler_idx_in,
  input  wire logic [vic_pkg::ADDR_W-1:0]                handler_addr_in,
  input  wire logic                                      vector_ack_in,
  output logic                                           irq_request_n_out,
  output logic                                           fast_irq_request_n_out,
  output logic [vic_pkg::ADDR_W-1:0]                     active_vector_out,
  output logic [vic_pkg::IDX_W-1:0]                      active_source_out,
  output logic [vic_pkg::NUM_SRC-1:0]                    raw_status_out
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [vic_pkg::NUM_SRC-1:0] src_raw;
  logic [vic_pkg::NUM_SRC-1:0] src_meta_reg;
  logic [vic_pkg::NUM_SRC-1:0] src_sync_reg;
  logic [vic_pkg::NUM_SRC-1:0] live_mask;
  logic [vic_pkg::NUM_SRC-1:0] armed;
  logic [vic_pkg::ADDR_W-1:0]  handler_table [vic_pkg::NUM_SRC];
  logic [vic_pkg::ADDR_W-1:0]  active_vector_reg;
  logic [vic_pkg::IDX_W-1:0]   active_source_reg;
  logic                        irq_n_reg;
  logic                        fiq_n_reg;
  vic_pkg::irq_state_t         state_reg;
  vic_pkg::irq_state_t         state_next;

  arb_if arb ();

  //////////////////////////////////////////////////////////////////////////////
  // Source map
  // wire sources to vectors
  always_comb
  begin
    src_raw = '0;
    src_raw[vic_pkg::VEC_WAKE]      = wake_event_source_in;
    src_raw[vic_pkg::VEC_SOFT]      = soft_request_source_in;
    src_raw[vic_pkg::VEC_TIMER]     = timer_source_in;
    src_raw[vic_pkg::VEC_PP_DMA]    = parallel_port_dma_source_in;
    src_raw[vic_pkg::VEC_PP_EVENT]  = parallel_port_event_source_in;
    src_raw[vic_pkg::VEC_USB_DMA]   = usb_dma_source_in;
    src_raw[vic_pkg::VEC_USB_EVENT] = usb_event_source_in;
    src_raw[vic_pkg::VEC_CARD_DMA]  = card_dma_source_in;
    src_raw[vic_pkg::VEC_CARD_A]    = card_port_a_source_in;
    src_raw[vic_pkg::VEC_CARD_B]    = card_port_b_source_in;
    src_raw[vic_pkg::VEC_I2C]       = i2c_source_in;
    src_raw[vic_pkg::VEC_I2S]       = i2s_source_in;
    src_raw[vic_pkg::VEC_SPI]       = spi_source_in;
    src_raw[vic_pkg::VEC_UART]      = uart_source_in;
    src_raw[vic_pkg::VEC_PIN_PORT]  = pin_port_source_in;
    src_raw[vic_pkg::VEC_SERIAL]    = serial_source_a_in;
    src_raw[vic_pkg::VEC_SUPPLY]    = supply_detect_source_in;
  end

  // unused vectors held off
  // Enables cannot wake an unused vector even if software sets them by mistake
  assign live_mask = vic_pkg::USED_MASK &
                     (STORAGE_VARIANT ? '1 : ~vic_pkg::STORAGE_MASK);

  // Sources may come from other clock or power domains, so all are synchronised
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      src_meta_reg <= '0;
      src_sync_reg <= '0;
    end
    else if (ce_in)
    begin
      src_meta_reg <= src_raw;
      src_sync_reg <= src_meta_reg;
    end
  end

  assign armed = src_sync_reg & live_mask & enable_in;

  //////////////////////////////////////////////////////////////////////////////
  // Configuration storage
  // handler address table
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < vic_pkg::NUM_SRC; i++)
      begin
        handler_table[i] <= vic_pkg::HANDLER_RESET;
      end
    end
    else if (ce_in && handler_wr_in)
    begin
      handler_table[handler_idx_in] <= handler_addr_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Arbitration
  // per-source priority
  assign arb.pending = armed & ~fast_select_in;
  always_comb
  begin
    for (int i = 0; i < vic_pkg::NUM_SRC; i++)
    begin
      arb.priority_lvl[i] = source_priority_in[i*vic_pkg::PRIO_W +: vic_pkg::PRIO_W];
    end
  end

  priority_arbiter u_arbiter (
    .port (arb.arbiter)
  );

  // fast request path
  // Fast sources bypass the vector sequencer, so the fast line is never blocked by a
  // normal request awaiting acknowledge
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      fiq_n_reg <= 1'b1;
    else if (ce_in)
      fiq_n_reg <= ~|(armed & fast_select_in);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Normal request sequencer
  // no nesting
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      vic_pkg::ST_IDLE:  if (arb.valid) state_next = vic_pkg::ST_LOAD;
      vic_pkg::ST_LOAD:  state_next = vic_pkg::ST_SERVE;
      vic_pkg::ST_SERVE: if (vector_ack_in) state_next = vic_pkg::ST_IDLE;
      default:           state_next = vic_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      state_reg <= vic_pkg::ST_IDLE;
    else if (ce_in)
      state_reg <= state_next;
  end

  // latch winner and address
  // The winner is frozen at idle so the loaded address always matches the source
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      active_source_reg <= '0;
      active_vector_reg <= vic_pkg::VECTOR_RESET;
    end
    else if (ce_in)
    begin
      if (state_reg == vic_pkg::ST_IDLE && arb.valid)
        active_source_reg <= arb.winner;
      if (state_reg == vic_pkg::ST_LOAD)
        active_vector_reg <= handler_table[active_source_reg];
    end
  end

  // drops on the same edge that the address is loaded
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      irq_n_reg <= 1'b1;
    else if (ce_in)
      irq_n_reg <= ~(state_next == vic_pkg::ST_SERVE);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      raw_status_out <= '0;
    else if (ce_in)
      raw_status_out <= src_sync_reg & live_mask;
  end

  assign irq_request_n_out      = irq_n_reg;
  assign fast_irq_request_n_out = fiq_n_reg;
  assign active_vector_out      = active_vector_reg;
  assign active_source_out      = active_source_reg;
endmodule

// ==== logic/vic_pkg.sv ====
// Constants, vector map and state encoding of the vectored interrupt controller
package vic_pkg;
  localparam int NUM_SRC = 32;
  localparam int IDX_W   = 5;
  localparam int PRIO_W  = 4;
  localparam int ADDR_W  = 32;

  // Vector numbers of the wired sources
  localparam int VEC_WAKE      = 0;
  localparam int VEC_SOFT      = 1;
  localparam int VEC_TIMER     = 4;
  localparam int VEC_PP_DMA    = 6;
  localparam int VEC_PP_EVENT  = 7;
  localparam int VEC_USB_DMA   = 8;
  localparam int VEC_USB_EVENT = 9;
  localparam int VEC_CARD_DMA  = 11;
  localparam int VEC_CARD_A    = 12;
  localparam int VEC_CARD_B    = 13;
  localparam int VEC_I2C       = 15;
  localparam int VEC_I2S       = 16;
  localparam int VEC_SPI       = 17;
  localparam int VEC_UART      = 18;
  localparam int VEC_PIN_PORT  = 19;
  localparam int VEC_SERIAL    = 20;
  localparam int VEC_SUPPLY    = 21;

  // Vectors that have a source behind them; all others can never request
  localparam logic [NUM_SRC-1:0] USED_MASK    = 32'h003f_bbd3;
  // Card interface vectors, present only on the storage-capable variant
  localparam logic [NUM_SRC-1:0] STORAGE_MASK = 32'h0000_3800;

  localparam logic [ADDR_W-1:0] HANDLER_RESET = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] VECTOR_RESET  = 32'h0000_0000;

  // Normal request sequencer, Gray along idle -> load -> serve
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LOAD  = 2'b01,
    ST_SERVE = 2'b11
  } irq_state_t;
endpackage

// ==== verification/cpu_model.sv ====
// Core model that acknowledges a normal request after a set wait
`timescale 1ns/1ns
module cpu_model (
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  input  wire logic       irq_n_in,
  input  wire logic [3:0] wait_in,
  output logic            ack_out
);
  logic [3:0] cnt_reg;
  //////////////////////////////////////////////////////////////////////////////
  // one write per request
  // The pause lets the handler clear its source before the acknowledge
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ack_out <= 1'b0;
      cnt_reg <= 4'h0;
    end
    else
    begin
      ack_out <= 1'b0;
      if (!ack_out && !irq_n_in)
      begin
        cnt_reg <= (cnt_reg == wait_in) ? 4'h0 : cnt_reg + 4'h1;
        ack_out <= (cnt_reg == wait_in);
      end
    end
  end
endmodule

// ==== verification/vectored_irq_source_map_bench.sv ====
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/1ns
module vectored_irq_source_map_bench;
  logic         clock_in, rst_in, ce, ack, hw_wr, irq_n, fast_n;
  logic [31:0]  src, en, fast, hw_addr, vec, raw, raw_lite;
  logic [127:0] prio;
  logic [4:0]   hw_idx, act;
  int           n_fail, n_tests;

  vectored_irq_source_map dut_u (
    .clock_in(clock_in), .rst_in(rst_in), .ce_in(ce),
    .wake_event_source_in(src[0]), .soft_request_source_in(src[1]),
    .timer_source_in(src[4]), .parallel_port_dma_source_in(src[6]),
    .parallel_port_event_source_in(src[7]), .usb_dma_source_in(src[8]),
    .usb_event_source_in(src[9]), .card_dma_source_in(src[11]),
    .card_port_a_source_in(src[12]), .card_port_b_source_in(src[13]),
    .i2c_source_in(src[15]), .i2s_source_in(src[16]), .spi_source_in(src[17]),
    .uart_source_in(src[18]), .pin_port_source_in(src[19]),
    .serial_source_a_in(src[20]), .supply_detect_source_in(src[21]),
    .enable_in(en), .fast_select_in(fast), .source_priority_in(prio),
    .handler_wr_in(hw_wr), .handler_idx_in(hw_idx), .handler_addr_in(hw_addr),
    .vector_ack_in(ack), .irq_request_n_out(irq_n), .fast_irq_request_n_out(fast_n),
    .active_vector_out(vec), .active_source_out(act), .raw_status_out(raw));
  cpu_model core_u (.clock_in(clock_in), .rst_in(rst_in), .irq_n_in(irq_n),
    .wait_in(4'h3), .ack_out(ack));
  // Variant without the card interface; it shares every input but only its status is connected and checked
  vectored_irq_source_map #(.STORAGE_VARIANT(1'b0)) dut_lite_u (
    .clock_in(clock_in), .rst_in(rst_in), .ce_in(ce),
    .wake_event_source_in(src[0]), .soft_request_source_in(src[1]),
    .timer_source_in(src[4]), .parallel_port_dma_source_in(src[6]),
    .parallel_port_event_source_in(src[7]), .usb_dma_source_in(src[8]),
    .usb_event_source_in(src[9]), .card_dma_source_in(src[11]),
    .card_port_a_source_in(src[12]), .card_port_b_source_in(src[13]),
    .i2c_source_in(src[15]), .i2s_source_in(src[16]), .spi_source_in(src[17]),
    .uart_source_in(src[18]), .pin_port_source_in(src[19]),
    .serial_source_a_in(src[20]), .supply_detect_source_in(src[21]),
    .enable_in(en), .fast_select_in(fast), .source_priority_in(prio),
    .handler_wr_in(hw_wr), .handler_idx_in(hw_idx), .handler_addr_in(hw_addr),
    .vector_ack_in(ack), .irq_request_n_out(), .fast_irq_request_n_out(),
    .active_vector_out(), .active_source_out(), .raw_status_out(raw_lite));
  //////////////////////////////////////////////////////////////////////////////
  // Clock
  initial
  begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  function automatic logic [31:0] haddr(int v);
    return 32'h2000_0000 + 32'(v) * 32'h10;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (n_fail == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge clock_in);
  endtask
  task automatic setup(logic [31:0] s, logic [31:0] e, logic [31:0] f);
    @(posedge clock_in);
    src <= s;
    en <= e;
    fast <= f;
  endtask
  // Bounded wait, sampled mid-cycle so edge updates have landed
  task automatic wait_irq(logic lvl);
    for (int i = 0; i < 30 && irq_n !== lvl; i++)
      @(negedge clock_in);
    chk(irq_n, lvl);
  endtask
  // Handler clears its source first, so the acknowledge is not followed by a repeat
  task automatic serve(int v);
    wait_irq(1'b0);
    chk(act, v);
    chk(vec, haddr(v));
    @(posedge clock_in);
    src[v] <= 1'b0;
    wait_irq(1'b1);
  endtask
  task automatic t_table;
    for (int v = 0; v < 32; v++)
    begin
      @(posedge clock_in);
      hw_wr <= 1'b1;
      hw_idx <= 5'(v);
      hw_addr <= haddr(v);
    end
    @(posedge clock_in);
    hw_wr <= 1'b0;
  endtask
  task automatic t_map;
    for (int v = 0; v < 32; v++)
      if (vic_pkg::USED_MASK[v])
      begin
        setup(32'h1 << v, 32'h1 << v, 32'h0);
        serve(v);
      end
  endtask
  // Vectors 15 and 19: first by level, then tied
  task automatic t_prio;
    @(posedge clock_in);
    prio[63:60] <= 4'h2;
    prio[79:76] <= 4'h1;
    setup(32'h0008_8000, 32'h0008_8000, 32'h0);
    serve(19);
    serve(15);
    @(posedge clock_in);
    prio[79:76] <= 4'h2;
    setup(32'h0008_8000, 32'h0008_8000, 32'h0);
    serve(15);
    serve(19);
  endtask
  task automatic t_fast;
    setup(32'h1, 32'h1, 32'h1);
    for (int i = 0; i < 10 && fast_n !== 1'b0; i++)
      @(negedge clock_in);
    chk(fast_n, 1'b0);
    tick(6);
    chk(irq_n, 1'b1);
    setup(32'h0, 32'h1, 32'h1);
    tick(6);
    chk(fast_n, 1'b1);
  endtask
  // Clock enable low freezes the sync stages, so the timer is only seen once it returns
  task automatic t_freeze;
    @(posedge clock_in);
    ce <= 1'b0;
    setup(32'h0000_0010, 32'h0000_0010, 32'h0);
    tick(8);
    chk(irq_n, 1'b1);
    chk(raw, 32'h0);
    @(posedge clock_in);
    ce <= 1'b1;
    serve(4);
  endtask
  task automatic t_mask;
    setup(32'hffff_ffff, 32'h0, 32'h0);
    tick(8);
    chk(raw, vic_pkg::USED_MASK);
    chk(raw_lite, vic_pkg::USED_MASK & ~vic_pkg::STORAGE_MASK);
    chk(irq_n & fast_n, 1'b1);
    setup(32'h0, 32'h0, 32'h0);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {src, en, fast, prio, hw_wr, hw_idx, hw_addr} = '0;
    rst_in = 1'b1;
    ce = 1'b1;
    n_fail = 0;
    n_tests = 0;
    repeat (20) @(posedge clock_in);
    rst_in <= 1'b0;
    tick(1);
    chk(irq_n & fast_n, 1'b1);
    chk(vec, vic_pkg::VECTOR_RESET);
    t_table;
    t_map;
    t_prio;
    t_fast;
    t_freeze;
    t_mask;
    give_verdict;
  end
  // Watchdog at 10000 cycles, well past the expected few hundred cycles
  initial
  begin
    #(40 * 10000);
    n_fail++;
    give_verdict;
  end
endmodule

// ==== verification/vic_checker_assertions.sv ====
// Port-level checks for the vectored interrupt controller
`timescale 1ns/1ns
module vic_checker (
  input wire logic        clock_in,
  input wire logic        rst_in,
  input wire logic        ce_in,
  input wire logic        wake_event_source_in,
  input wire logic [31:0] enable_in,
  input wire logic [31:0] fast_select_in,
  input wire logic        vector_ack_in,
  input wire logic        irq_request_n_out,
  input wire logic        fast_irq_request_n_out,
  input wire logic [31:0] active_vector_out,
  input wire logic [4:0]  active_source_out,
  input wire logic [31:0] raw_status_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  //////////////////////////////////////////////////////////////////////////////
  // Status and fast path
  property p_unused; (raw_status_out & ~vic_pkg::USED_MASK) == 32'h0000_0000; endproperty
  a_unused: assert property (p_unused) else $error("unused vector shows status");
  property p_wake_raw; (ce_in && wake_event_source_in) [*3] |=> raw_status_out[0]; endproperty
  a_wake_raw: assert property (p_wake_raw) else $error("wake status missing");
  sequence s_wake_fast;
    ce_in && wake_event_source_in && enable_in[0] && fast_select_in[0];
  endsequence
  property p_fast_on; s_wake_fast [*3] |=> !fast_irq_request_n_out; endproperty
  a_fast_on: assert property (p_fast_on) else $error("fast request late");
  property p_no_fast; (fast_select_in == 32'h0) [*4] |-> fast_irq_request_n_out; endproperty
  a_no_fast: assert property (p_no_fast) else $error("fast request without source");
  // Normal request holds until the acknowledge, which is why no nesting can occur
  property p_hold;
    !irq_request_n_out && !vector_ack_in |=> !irq_request_n_out
      && $stable(active_vector_out) && $stable(active_source_out);
  endproperty
  a_hold: assert property (p_hold) else $error("request changed before ack");
  property p_ack; ce_in && !irq_request_n_out && vector_ack_in |=> irq_request_n_out; endproperty
  a_ack: assert property (p_ack) else $error("ack did not drop request");
  property p_gap; $rose(irq_request_n_out) |=> irq_request_n_out; endproperty
  a_gap: assert property (p_gap) else $error("request gap too short");
  property p_pick;
    $fell(irq_request_n_out) |-> enable_in[active_source_out]
      && !fast_select_in[active_source_out];
  endproperty
  a_pick: assert property (p_pick) else $error("served source not enabled normal");
  property p_used; $fell(irq_request_n_out) |-> vic_pkg::USED_MASK[active_source_out]; endproperty
  a_used: assert property (p_used) else $error("served an unused vector");
  c_fast: cover property ($fell(fast_irq_request_n_out));
  c_irq: cover property ($fell(irq_request_n_out));
  c_ack: cover property (!irq_request_n_out && vector_ack_in);
endmodule

bind vectored_irq_source_map vic_checker chk_u (
  .clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in),
  .wake_event_source_in(wake_event_source_in), .enable_in(enable_in),
  .fast_select_in(fast_select_in), .vector_ack_in(vector_ack_in),
  .irq_request_n_out(irq_request_n_out), .fast_irq_request_n_out(fast_irq_request_n_out),
  .active_vector_out(active_vector_out), .active_source_out(active_source_out),
  .raw_status_out(raw_status_out));
